// *** design/pdp_port_regs.sv ***
// port data latches and pull-up selection registers
`include "pdp_regs.svh"
`timescale 1ns/1ns
`default_nettype none

module pdp_port_regs
    import pdp_pkg::*;
#(
    parameter int PORTS = 8,
    parameter logic [3:0] OD_PULLUP_MASK = 4'h0
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // processor access
    input wire logic cpu_req,
    input wire pdp_op_t cpu_op,
    input wire logic [15:0] cpu_addr,
    input wire logic [2:0] cpu_bit,
    input wire logic [7:0] cpu_wdata,
    output logic [7:0] cpu_rdata,
    output logic cpu_ack,
    // direction and alternate-function state from outside this block
    input wire logic [PORTS-1:0][7:0] direction_register,
    input wire logic [PORTS-1:0][7:0] alt_out_active,
    // pins
    input wire logic [PORTS-1:0][7:0] pin_in,
    output logic [PORTS-1:0][7:0] pin_out,
    output logic [PORTS-1:0][7:0] pin_oe_n,
    output logic [PORTS-1:0][7:0] pullup_en
);

    // the slot tables are built for exactly eight ports
    initial begin
        if (PORTS != 8) begin
            $error("pdp_port_regs serves exactly eight port slots");
        end
    end

    localparam logic [127:0] DATA_OFS = `PDP_DATA_OFS_TABLE;
    localparam logic [127:0] PU_OFS = `PDP_PULLUP_OFS_TABLE;
    localparam logic [63:0] IMPL = `PDP_IMPL_MASKS;
    localparam logic [63:0] WMASK = `PDP_WRITE_MASKS;
    localparam logic [63:0] PUMASK = `PDP_PULLUP_MASKS;
    localparam logic [63:0] FIN = `PDP_FORCE_IN_MASKS;
    localparam logic [63:0] FOUT = `PDP_FORCE_OUT_MASKS;
    localparam logic [63:0] ODMASK = `PDP_OPEN_DRAIN_MASKS;
    localparam int OD_SLOT = 4;

    // compute the value stored back by a write or a bit operation
    function automatic pdp_byte_t pdp_apply(
        input pdp_op_t op,
        input pdp_byte_t operand,
        input logic [2:0] bsel,
        input pdp_byte_t wdata
    );
        pdp_byte_t onehot;
        pdp_byte_t res;
        onehot = 8'h01 << bsel;
        case (op)
            PDP_OP_WRITE: res = wdata;
            PDP_OP_BIT_SET: res = operand | onehot;
            PDP_OP_BIT_CLR: res = operand & ~onehot;
            PDP_OP_BIT_NOT: res = operand ^ onehot;
            default: res = operand;
        endcase
        return res;
    endfunction

    // per-slot read contributions and hit flags
    logic [PORTS-1:0][7:0] data_rd;
    logic [PORTS-1:0][7:0] pu_rd;
    logic [PORTS-1:0] data_hit;
    logic [PORTS-1:0] pu_hit;
    logic [7:0] operand;
    logic [7:0] new_val;
    logic wr_op;
    logic [7:0] cpu_rdata_q;
    logic cpu_ack_q;

    // reads of any kind leave storage alone; only writing ops store
    assign wr_op = cpu_op != PDP_OP_READ;

    // one byte operand drives every access, so a bit operation rewrites
    // the whole byte: input-bit latches pick up the pin level
    assign new_val = pdp_apply(cpu_op, operand, cpu_bit, cpu_wdata);

    // read mux: unmapped addresses return zero
    always_comb begin
        operand = 8'h00;
        for (int s = 0; s < PORTS; s++) begin
            operand = operand | data_rd[s] | pu_rd[s];
        end
    end

    genvar s;
    generate
        for (s = 0; s < PORTS; s++) begin : g_slot
            localparam logic [7:0] IM = IMPL[s*8 +: 8];
            localparam logic [7:0] WM = WMASK[s*8 +: 8];
            localparam logic [7:0] PM = PUMASK[s*8 +: 8];
            localparam logic [7:0] FI = FIN[s*8 +: 8];
            localparam logic [7:0] FO = FOUT[s*8 +: 8];
            localparam logic [7:0] OD = ODMASK[s*8 +: 8];
            localparam logic [15:0] DOFS = DATA_OFS[s*16 +: 16];
            localparam logic [15:0] POFS = PU_OFS[s*16 +: 16];

            logic [7:0] sync1_q;
            logic [7:0] sync2_q;
            logic [7:0] latch_q;
            logic [7:0] latch_d;
            logic [7:0] pu_q;
            logic [7:0] pu_d;
            logic [7:0] in_mode;
            logic [7:0] oe_n_q;
            logic [7:0] oe_n_d;
            logic [7:0] pull_q;
            logic [7:0] pull_d;

            // effective direction: one is input; fixed-direction ports
            // override whatever the direction register holds
            assign in_mode = (direction_register[s] | FI) & ~FO & IM;

            // address decode; ports without pull-ups decode no pull-up
            assign data_hit[s] = cpu_req && cpu_addr == DOFS;
            assign pu_hit[s] = cpu_req && (PM != 8'h00) && cpu_addr == POFS;

            // pin level for input bits, latch for output bits
            assign data_rd[s] = data_hit[s] ?
                (((sync2_q & in_mode)
                | (latch_q & ~in_mode)) & IM) : 8'h00;
            assign pu_rd[s] = pu_hit[s] ? (pu_q & PM) : 8'h00;

            // latch loads on any writing op regardless of direction and
            // holds otherwise; the input-only port has no writable bits
            assign latch_d = (data_hit[s] && wr_op) ?
                (new_val & WM) : latch_q;

            assign pu_d = (pu_hit[s] && wr_op) ? (new_val & PM) : pu_q;

            // open-drain bits only pull low; a latch one releases the pin
            assign oe_n_d = in_mode | (OD & latch_q) | ~IM;

            // pull-up needs the select bit, input mode and no alternate
            // output; OD_SLOT (slot 4, port 6) only has the fixed option, gated by input mode alone
            if (s == OD_SLOT) begin : g_od
                assign pull_d = {4'h0, OD_PULLUP_MASK} & in_mode;
            end else begin : g_pu
                assign pull_d = pu_q & PM & in_mode
                    & ~alt_out_active[s];
            end

            // two-flop synchroniser on the pins; only stage two is read
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    sync1_q <= `PDP_SYNC_RESET;
                    sync2_q <= `PDP_SYNC_RESET;
                end else begin
                    sync1_q <= pin_in[s];
                    sync2_q <= sync1_q;
                end
            end

            // output latch; read-modify-write stores the computed result
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    latch_q <= `PDP_LATCH_RESET;
                end else begin
                    latch_q <= latch_d;
                end
            end

            // pull-up selection register
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    pu_q <= `PDP_PULLUP_RESET;
                end else begin
                    pu_q <= pu_d;
                end
            end

            // registered pin controls; drivers start off so every pin
            // begins as an input, matching the direction reset
            always_ff @(posedge clk_sys or negedge rst_n) begin
                if (!rst_n) begin
                    oe_n_q <= `PDP_DIR_RESET;
                    pull_q <= `PDP_PULLUP_RESET;
                end else begin
                    oe_n_q <= oe_n_d;
                    pull_q <= pull_d;
                end
            end

            assign pin_out[s] = latch_q;
            assign pin_oe_n[s] = oe_n_q;
            assign pullup_en[s] = pull_q;
        end
    endgenerate

    // answer one cycle after the request; rdata holds until the next one
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cpu_rdata_q <= 8'h00;
            cpu_ack_q <= 1'b0;
        end else begin
            cpu_ack_q <= cpu_req;
            if (cpu_req) begin
                cpu_rdata_q <= operand;
            end
        end
    end

    assign cpu_rdata = cpu_rdata_q;
    assign cpu_ack = cpu_ack_q;

endmodule

`default_nettype wire

// *** design/pdp_regs.svh ***
// register offsets, bit masks and reset values of the port data block
`ifndef PDP_REGS_SVH
`define PDP_REGS_SVH

// data register offsets
`define PDP_PORT0_DATA_LATCH_OFS 16'hff00
`define PDP_PORT1_DATA_LATCH_OFS 16'hff01
`define PDP_PORT2_INPUT_LEVEL_OFS 16'hff02
`define PDP_PORT3_DATA_LATCH_OFS 16'hff03
`define PDP_PORT6_DATA_LATCH_OFS 16'hff06
`define PDP_PORT7_DATA_LATCH_OFS 16'hff07
`define PDP_PORT12_DATA_LATCH_OFS 16'hff0c
`define PDP_PORT13_DATA_LATCH_OFS 16'hff0d

// pull-up selection offsets
`define PDP_PULLUP_SELECT_PORT0_OFS 16'hff30
`define PDP_PULLUP_SELECT_PORT1_OFS 16'hff31
`define PDP_PULLUP_SELECT_PORT3_OFS 16'hff33
`define PDP_PULLUP_SELECT_PORT7_OFS 16'hff37
`define PDP_PULLUP_SELECT_PORT12_OFS 16'hff3c
`define PDP_NO_OFS 16'h0000

// per-slot offset tables, slot 7 in the top bits
`define PDP_DATA_OFS_TABLE {`PDP_PORT13_DATA_LATCH_OFS, \
    `PDP_PORT12_DATA_LATCH_OFS, `PDP_PORT7_DATA_LATCH_OFS, \
    `PDP_PORT6_DATA_LATCH_OFS, `PDP_PORT3_DATA_LATCH_OFS, \
    `PDP_PORT2_INPUT_LEVEL_OFS, `PDP_PORT1_DATA_LATCH_OFS, \
    `PDP_PORT0_DATA_LATCH_OFS}
`define PDP_PULLUP_OFS_TABLE {`PDP_NO_OFS, \
    `PDP_PULLUP_SELECT_PORT12_OFS, `PDP_PULLUP_SELECT_PORT7_OFS, \
    `PDP_NO_OFS, `PDP_PULLUP_SELECT_PORT3_OFS, `PDP_NO_OFS, \
    `PDP_PULLUP_SELECT_PORT1_OFS, `PDP_PULLUP_SELECT_PORT0_OFS}

// per-slot bit masks, one byte per slot, slot 7 in the top byte
`define PDP_IMPL_MASKS 64'h01010f0f0fffff03
`define PDP_WRITE_MASKS 64'h01010f0f0f00ff03
`define PDP_PULLUP_MASKS 64'h00010f000f00ff03
`define PDP_FORCE_IN_MASKS 64'h0000000000ff0000
`define PDP_FORCE_OUT_MASKS 64'h0100000000000000
`define PDP_OPEN_DRAIN_MASKS 64'h000000000f000000

// reset values
`define PDP_LATCH_RESET 8'h00
`define PDP_PULLUP_RESET 8'h00
`define PDP_DIR_RESET 8'hff
`define PDP_SYNC_RESET 8'h00

`endif

// *** design/pdp_pkg.sv ***
// types shared by the port data and pull-up block
`default_nettype none
package pdp_pkg;
    // processor access kinds; bit kinds run as a byte read-modify-write
    typedef enum logic [2:0] {
        PDP_OP_READ,
        PDP_OP_WRITE,
        PDP_OP_BIT_SET,
        PDP_OP_BIT_CLR,
        PDP_OP_BIT_NOT
    } pdp_op_t;
    typedef logic [7:0] pdp_byte_t;
endpackage
`default_nettype wire

// *** bench/pdp_port_regs_props.sv ***
// port-level assertions for the port data and pull-up block
`include "pdp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module pdp_port_regs_props
    import pdp_pkg::*;
#(
    parameter int PORTS = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // processor access
    input wire logic cpu_req,
    input wire pdp_op_t cpu_op,
    input wire logic [15:0] cpu_addr,
    input wire logic [7:0] cpu_wdata,
    input wire logic [7:0] cpu_rdata,
    input wire logic cpu_ack,
    // mode state and pins
    input wire logic [PORTS-1:0][7:0] direction_register,
    input wire logic [PORTS-1:0][7:0] alt_out_active,
    input wire logic [PORTS-1:0][7:0] pin_out,
    input wire logic [PORTS-1:0][7:0] pin_oe_n,
    input wire logic [PORTS-1:0][7:0] pullup_en
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // pin enables are registered, so they answer the previous mode
    a_ack_after_req: assert property (
        cpu_req |=> cpu_ack) else $error("ack missing");
    a_ack_only_req: assert property (
        cpu_ack |-> $past(cpu_req)) else $error("stray ack");
    a_write_loads: assert property (
        cpu_req && cpu_op == PDP_OP_WRITE && cpu_addr == 16'hff01
        |=> pin_out[1] == $past(cpu_wdata)) else $error("latch not loaded");
    a_read_latch: assert property (
        cpu_req && cpu_op == PDP_OP_READ && cpu_addr == 16'hff01 &&
        direction_register[1] == 8'h00 |=> cpu_rdata == $past(pin_out[1]))
        else $error("output read wrong");
    a_latch_holds: assert property (
        !(cpu_req && cpu_op != PDP_OP_READ) |=> $stable(pin_out))
        else $error("latch moved without write");
    a_pullup_gated: assert property (
        (pullup_en & ($past(alt_out_active) | ~$past(direction_register)))
        == 64'h0) else $error("pull-up on driven pin");
    a_pullup_slots: assert property (
        (pullup_en & ~`PDP_PULLUP_MASKS) == 64'h0) else $error("bad pull-up");
    a_input_undriven: assert property (
        (~pin_oe_n & $past(direction_register) & ~`PDP_FORCE_OUT_MASKS)
        == 64'h0) else $error("input pin driven");
    a_output_driven: assert property (
        (pin_oe_n & ~$past(direction_register) & `PDP_IMPL_MASKS &
        ~`PDP_FORCE_IN_MASKS & ~`PDP_OPEN_DRAIN_MASKS) == 64'h0)
        else $error("output pin not driven");
endmodule
bind pdp_port_regs pdp_port_regs_props #(.PORTS(PORTS)) u_props (
    .clk_sys(clk_sys), .rst_n(rst_n), .cpu_req(cpu_req), .cpu_op(cpu_op),
    .cpu_addr(cpu_addr), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata),
    .cpu_ack(cpu_ack), .direction_register(direction_register),
    .alt_out_active(alt_out_active), .pin_out(pin_out),
    .pin_oe_n(pin_oe_n), .pullup_en(pullup_en));
`default_nettype wire

// *** bench/pdp_pin_board.sv ***
// board model: resolves every pin from driver, pull-up and board level
`timescale 1ns/1ns
`default_nettype none
module pdp_pin_board (
    // device side
    input wire logic [7:0][7:0] pin_out,
    input wire logic [7:0][7:0] pin_oe_n,
    input wire logic [7:0][7:0] pullup_en,
    // board side
    input wire logic [7:0][7:0] ext_level,
    output logic [7:0][7:0] pin_level
);
    // a driven pin wins; a released one sits at pull-up or board level
    assign pin_level = (~pin_oe_n & pin_out) |
        (pin_oe_n & (pullup_en | ext_level));
endmodule
`default_nettype wire

// *** bench/test_pdp_port_regs.sv ***
// self-checking bench for the port data and pull-up block
`include "pdp_regs.svh"
`timescale 1ns/1ns
`default_nettype none
module test_pdp_port_regs;
    import pdp_pkg::*;
    logic clk_sys = 0, rst_n = 0, cpu_req = 0, cpu_ack;
    pdp_op_t cpu_op = PDP_OP_READ;
    logic [15:0] cpu_addr = 16'h0000;
    logic [2:0] cpu_bit = 3'h0, b = 3'h0;
    logic [7:0] cpu_wdata = 8'h00, cpu_rdata, rd, w, e, d;
    logic [7:0][7:0] dir = '1, alt = '0, ext = '0, pin, pout, oen, pu;
    logic [7:0][15:0] ofs = `PDP_DATA_OFS_TABLE;
    logic [63:0] wm = `PDP_WRITE_MASKS;
    int bad_count = 0, n_checks = 0, cycles = 0, seed = 12;
    pdp_pin_board board (.pin_out(pout), .pin_oe_n(oen), .pullup_en(pu),
        .ext_level(ext), .pin_level(pin));
    pdp_port_regs dut (.clk_sys(clk_sys), .rst_n(rst_n), .cpu_req(cpu_req),
        .cpu_op(cpu_op), .cpu_addr(cpu_addr), .cpu_bit(cpu_bit),
        .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata), .cpu_ack(cpu_ack),
        .direction_register(dir), .alt_out_active(alt), .pin_in(pin),
        .pin_out(pout), .pin_oe_n(oen), .pullup_en(pu));
    initial begin
        forever #10 clk_sys = ~clk_sys;
    end
    // hang guard: the sequence needs well under 1000 cycles
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            bad_count = bad_count + 1;
            print_verdict();
        end
    end
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            bad_count = bad_count + 1;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask
    // inputs move 2 ns after the edge so the design never races them
    task automatic step(int n);
        repeat (n) @(posedge clk_sys);
        #2;
    endtask
    // one-cycle request; ack and read data stand in the next cycle
    task automatic access(pdp_op_t op, logic [15:0] a, logic [7:0] v);
        step(1);
        cpu_req = 1;
        cpu_op = op;
        cpu_addr = a;
        cpu_bit = b;
        cpu_wdata = v;
        step(1);
        cpu_req = 0;
        check("ack", 8'h01, {7'h00, cpu_ack});
        rd = cpu_rdata;
    endtask
    function automatic logic [7:0] bit_op(pdp_op_t op, logic [7:0] v);
        case (op)
            PDP_OP_BIT_SET: return v | (8'h01 << b);
            PDP_OP_BIT_CLR: return v & ~(8'h01 << b);
            default: return v ^ (8'h01 << b);
        endcase
    endfunction
    initial begin
        step(5);
        rst_n = 1;
        step(3);
        check("oe_n", 8'hff, oen[1]);
        access(PDP_OP_READ, `PDP_PULLUP_SELECT_PORT1_OFS, 8'h00);
        check("pu1", 8'h00, rd);
        dir = '0;
        for (int s = 0; s < 8; s++) begin
            access(PDP_OP_READ, ofs[s], 8'h00);
            if (s != 2) check("reset", 8'h00, rd);
        end
        // random bytes, first round all ones, every slot but the input-only slot 2 in output mode
        for (int r = 0; r < 3; r++) begin
            ext = {$random(seed), $random(seed)};
            for (int s = 0; s < 8; s++) begin
                w = (r == 0) ? 8'hff : 8'($random(seed));
                access(PDP_OP_WRITE, ofs[s], w);
                access(PDP_OP_READ, ofs[s], 8'h00);
                e = (s == 2) ? ext[2] : w & wm[s*8 +: 8];
                check("data", e, rd);
                if (s != 2) check("latch", e, pout[s]);
            end
        end
        access(PDP_OP_WRITE, 16'hff05, 8'ha5);
        access(PDP_OP_READ, 16'hff05, 8'h00);
        check("unmapped", 8'h00, rd);
        // write in input mode reaches the latch but not the pin
        dir = '1;
        w = 8'($random(seed));
        access(PDP_OP_WRITE, 16'hff01, w);
        access(PDP_OP_READ, 16'hff01, 8'h00);
        check("in_read", ext[1], rd);
        check("in_pin", ext[1], pin[1]);
        dir = '0;
        access(PDP_OP_READ, 16'hff01, 8'h00);
        check("held", w, rd);
        // bit ops on mixed direction take pin for inputs, latch for outputs
        for (int k = 2; k < 5; k++) begin
            w = 8'($random(seed));
            access(PDP_OP_WRITE, 16'hff01, w);
            d = 8'($random(seed));
            dir[1] = d;
            b = 3'($random(seed));
            step(3);
            access(pdp_op_t'(k), 16'hff01, 8'h00);
            e = bit_op(pdp_op_t'(k), (ext[1] & d) | (w & ~d));
            dir = '0;
            access(PDP_OP_READ, 16'hff01, 8'h00);
            check("bit_op", e, rd);
        end
        w = 8'($random(seed));
        access(PDP_OP_WRITE, `PDP_PULLUP_SELECT_PORT1_OFS, w);
        access(PDP_OP_WRITE, `PDP_PULLUP_SELECT_PORT7_OFS, 8'hff);
        access(PDP_OP_READ, `PDP_PULLUP_SELECT_PORT7_OFS, 8'h00);
        check("pu7", 8'h0f, rd);
        dir = {$random(seed), $random(seed)};
        alt = {$random(seed), $random(seed)};
        step(2);
        check("pullup", w & dir[1] & ~alt[1], pu[1]);
        print_verdict();
    end
endmodule
`default_nettype wire
